// ==== hw/urx_pkg.sv ====
// Purpose: shared constants and types for the receive parity/flush block
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: register map is a plain strobe port with read data one cycle later
package urx_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [2:0] URX_OFS_DATA = 3'h0;
   localparam logic [2:0] URX_OFS_STAT = 3'h1;
   localparam logic [2:0] URX_OFS_CTRL = 3'h2;
   localparam logic [2:0] URX_OFS_IRQ_STAT = 3'h3;
   localparam logic [2:0] URX_OFS_IRQ_MASK = 3'h4;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int URX_STAT_RX_COMPLETE_BIT = 7;
   localparam int URX_STAT_FE_BIT = 4;
   localparam int URX_STAT_PERR_BIT = 2;
   localparam int URX_CTRL_ENABLE_BIT = 0;
   localparam int URX_CTRL_PODD_BIT = 1;
   localparam int URX_CTRL_PEN_BIT = 2;
   localparam int URX_IRQ_RX_BIT = 0;
   localparam int URX_IRQ_PERR_BIT = 1;
   localparam int URX_IRQ_FLUSH_BIT = 2;
   // ------------------------------------------------------------
   // reset values and sizes
   // ------------------------------------------------------------
   localparam logic [2:0] URX_CTRL_RST = 3'h0;
   localparam logic [2:0] URX_IRQ_RST = 3'h0;
   localparam int URX_DEPTH = 2;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] data;
      logic stop_ok;
      logic perr;
   } urx_entry_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } urx_bus_t;
endpackage : urx_pkg

// ==== hw/urx_parity_flush.sv ====
// What this block does
// - parity is compared only while parity_check_enable is one, never when zero.
// - parity_odd_select chooses odd or even parity for the enabled check.
// - the parity of the received data bits is compared with the frame's parity bit.
// - the comparison outcome is stored in the buffer entry with the data and stop status.
// - parity_error_flag reads one only if the oldest unread character failed with checking on.
// - parity_error_flag holds for the current character until the data location is read.
// - clearing receiver_enable_bit stops reception at once and drops any partial frame.
// - while disabled the receive pin is released to its ordinary port function.
// - disabling empties the buffer with all stored status.
// - rx_complete_flag is one whenever at least one unread character is buffered.
// - the buffer holds two characters with status beside the shift register.
// - with checking disabled parity_error_flag reads zero.
// - a read of the data location with a character buffered advances the read pointer to the next character.
//
// Purpose: receive buffer, parity checker and receiver disable/flush
// Assumes: frame assembly delivers one load pulse per complete frame
// Notes: interrupt status bits clear on write of one; set wins over clear
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module urx_parity_flush
   import urx_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic shift_load,
   input wire logic [7:0] shift_data,
   input wire logic shift_parity,
   input wire logic shift_stop,
   output logic rx_enable,
   output logic rx_pin_override,
   output logic irq
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      urx_entry_t [URX_DEPTH-1:0] buf_q;
      logic rptr;
      logic wptr;
      logic [1:0] count;
      logic [2:0] ctrl;
      logic [2:0] istat;
      logic [2:0] imask;
      logic [7:0] rdata;
      logic enable_out;
      logic pin_out;
      logic irq_out;
   } urx_state_t;

   urx_state_t st_r;
   urx_state_t st_nxt;
   urx_bus_t bus;
   urx_entry_t head;
   urx_entry_t incoming;
   logic enabled;
   logic pen;
   logic podd;
   logic perr_calc;
   logic do_read;
   logic do_write;
   logic disable_now;
   logic [7:0] stat_val;
   logic [2:0] ev;

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign enabled = st_r.ctrl[URX_CTRL_ENABLE_BIT];
   assign pen = st_r.ctrl[URX_CTRL_PEN_BIT];
   assign podd = st_r.ctrl[URX_CTRL_PODD_BIT];
   assign head = st_r.buf_q[st_r.rptr];

   // ------------------------------------------------------------
   // parity check
   // ------------------------------------------------------------
   // even: xor of data and parity must be zero; odd: must be one
   assign perr_calc = pen & ((^shift_data ^ shift_parity) != podd);
   assign incoming = '{data: shift_data, stop_ok: shift_stop, perr: perr_calc};

   // ------------------------------------------------------------
   // bus decode and status view
   // ------------------------------------------------------------
   assign do_read = bus.rd && bus.addr == URX_OFS_DATA && st_r.count != 2'h0;
   assign do_write = bus.wr && bus.addr == URX_OFS_CTRL;
   assign disable_now = do_write && !bus.wdata[URX_CTRL_ENABLE_BIT];

   always_comb begin
      stat_val = 8'h00;
      stat_val[URX_STAT_RX_COMPLETE_BIT] = st_r.count != 2'h0;
      stat_val[URX_STAT_FE_BIT] = st_r.count != 2'h0 && !head.stop_ok;
      // parity flag follows the head entry and is masked while checking is off
      stat_val[URX_STAT_PERR_BIT] = st_r.count != 2'h0 && head.perr && pen;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      ev = 3'h0;
      if (do_write) begin
         st_nxt.ctrl = bus.wdata[2:0];
      end
      if (do_read) begin
         st_nxt.rptr = ~st_r.rptr;
      end
      // a load arriving with the buffer full is dropped unless the data location is read in the same cycle
      if (enabled && !disable_now && shift_load && (st_r.count != 2'(URX_DEPTH) || do_read)) begin
         st_nxt.buf_q[st_r.wptr] = incoming;
         st_nxt.wptr = ~st_r.wptr;
         ev[URX_IRQ_RX_BIT] = 1'b1;
         ev[URX_IRQ_PERR_BIT] = perr_calc;
      end
      st_nxt.count = st_r.count + 2'(ev[URX_IRQ_RX_BIT]) - 2'(do_read);
      if (disable_now) begin
         st_nxt.count = 2'h0;
         st_nxt.rptr = 1'b0;
         st_nxt.wptr = 1'b0;
         st_nxt.buf_q = '0;
         ev[URX_IRQ_FLUSH_BIT] = st_r.count != 2'h0;
      end
      if (bus.wr && bus.addr == URX_OFS_IRQ_MASK) begin
         st_nxt.imask = bus.wdata[2:0];
      end
      if (bus.wr && bus.addr == URX_OFS_IRQ_STAT) begin
         st_nxt.istat = st_r.istat & ~bus.wdata[2:0];
      end
      st_nxt.istat = st_nxt.istat | ev;
      st_nxt.rdata = 8'h00;
      if (bus.rd) begin
         if (bus.addr == URX_OFS_DATA) begin
            st_nxt.rdata = st_r.count != 2'h0 ? head.data : 8'h00;
         end else if (bus.addr == URX_OFS_STAT) begin
            st_nxt.rdata = stat_val;
         end else if (bus.addr == URX_OFS_CTRL) begin
            st_nxt.rdata = {5'h00, st_r.ctrl};
         end else if (bus.addr == URX_OFS_IRQ_STAT) begin
            st_nxt.rdata = {5'h00, st_r.istat};
         end else if (bus.addr == URX_OFS_IRQ_MASK) begin
            st_nxt.rdata = {5'h00, st_r.imask};
         end else begin
            st_nxt.rdata = 8'h00;
         end
      end
      st_nxt.enable_out = st_nxt.ctrl[URX_CTRL_ENABLE_BIT];
      st_nxt.pin_out = st_nxt.ctrl[URX_CTRL_ENABLE_BIT];
      st_nxt.irq_out = |(st_nxt.istat & st_nxt.imask);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '0;
         st_r.ctrl <= URX_CTRL_RST;
         st_r.imask <= URX_IRQ_RST;
         st_r.istat <= URX_IRQ_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign rx_enable = st_r.enable_out;
   assign rx_pin_override = st_r.pin_out;
   assign irq = st_r.irq_out;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_load_perr;
      enabled && !disable_now && shift_load && st_r.count == 2'h0 && perr_calc;
   endsequence

   sequence s_load_empty;
      enabled && !disable_now && shift_load && st_r.count == 2'h0;
   endsequence

   sequence s_load_one;
      enabled && !disable_now && shift_load && st_r.count == 2'h1 && !do_read;
   endsequence

   property p_perr_off_zero;
      @(posedge clk) disable iff (srst) bus.rd && bus.addr == URX_OFS_STAT && !pen |=> !reg_rdata[URX_STAT_PERR_BIT];
   endproperty
   a_perr_off_zero: assert property (p_perr_off_zero) else $error("parity flag set while checking off");

   property p_no_check_off;
      @(posedge clk) disable iff (srst) s_load_empty ##0 !pen |=> !head.perr;
   endproperty
   a_no_check_off: assert property (p_no_check_off) else $error("parity error without enable");

   property p_parity_calc;
      @(posedge clk) disable iff (srst) s_load_empty ##0 pen
         |=> head.perr == ((^$past(shift_data) ^ $past(shift_parity)) != $past(podd));
   endproperty
   a_parity_calc: assert property (p_parity_calc) else $error("parity compare wrong");

   property p_perr_stored;
      @(posedge clk) disable iff (srst) s_load_perr |=> head.perr && st_r.count == 2'h1;
   endproperty
   a_perr_stored: assert property (p_perr_stored) else $error("parity outcome not stored");

   property p_perr_head;
      @(posedge clk) disable iff (srst) s_load_perr ##1 (pen && !bus.rd && !disable_now)
         ##1 (bus.rd && bus.addr == URX_OFS_STAT && pen)
         |=> reg_rdata[URX_STAT_PERR_BIT];
   endproperty
   a_perr_head: assert property (p_perr_head) else $error("parity flag not shown for head");

   property p_flush;
      @(posedge clk) disable iff (srst) disable_now |=> st_r.count == 2'h0 && !rx_enable && !rx_pin_override;
   endproperty
   a_flush: assert property (p_flush) else $error("disable did not flush");

   property p_rx_complete;
      @(posedge clk) disable iff (srst) bus.rd && bus.addr == URX_OFS_STAT
         |=> reg_rdata[URX_STAT_RX_COMPLETE_BIT] == ($past(st_r.count) != 2'h0);
   endproperty
   a_rx_complete: assert property (p_rx_complete) else $error("receive complete flag mismatch");

   property p_depth;
      @(posedge clk) disable iff (srst) st_r.count <= 2'(URX_DEPTH);
   endproperty
   a_depth: assert property (p_depth) else $error("buffer over depth");

   property p_advance;
      @(posedge clk) disable iff (srst) do_read && !disable_now |=> st_r.rptr != $past(st_r.rptr);
   endproperty
   a_advance: assert property (p_advance) else $error("read did not advance");

   property p_irq;
      @(posedge clk) disable iff (srst) ##1 irq == |($past(st_nxt.istat) & $past(st_nxt.imask));
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   // ------------------------------------------------------------
   // buffer, bus and interrupt checks
   // ------------------------------------------------------------
   property p_read_empty;
      @(posedge clk) disable iff (srst)
         bus.rd && bus.addr == URX_OFS_DATA && st_r.count == 2'h0
         |=> reg_rdata == 8'h00;
   endproperty
   a_read_empty: assert property (p_read_empty) else $error("empty data read not zero");

   property p_rdata_idle;
      @(posedge clk) disable iff (srst)
         !bus.rd
         |=> reg_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

   property p_load_count;
      @(posedge clk) disable iff (srst)
         s_load_one
         |=> st_r.count == 2'h2;
   endproperty
   a_load_count: assert property (p_load_count) else $error("second character not held");

   property p_full_drop;
      @(posedge clk) disable iff (srst)
         enabled && !disable_now && shift_load && st_r.count == 2'h2 && !do_read
         |=> st_r.count == 2'h2;
   endproperty
   a_full_drop: assert property (p_full_drop) else $error("full buffer count changed");

   property p_read_dec;
      @(posedge clk) disable iff (srst)
         do_read && !shift_load
         |=> st_r.count == $past(st_r.count) - 2'h1;
   endproperty
   a_read_dec: assert property (p_read_dec) else $error("read did not consume");

   property p_disabled_empty;
      @(posedge clk) disable iff (srst)
         !enabled
         |-> st_r.count == 2'h0;
   endproperty
   a_disabled_empty: assert property (p_disabled_empty) else $error("data held while disabled");

   property p_enable_on;
      @(posedge clk) disable iff (srst)
         do_write && bus.wdata[URX_CTRL_ENABLE_BIT]
         |=> rx_enable && rx_pin_override;
   endproperty
   a_enable_on: assert property (p_enable_on) else $error("enable not taken");

   property p_mask_write;
      @(posedge clk) disable iff (srst)
         bus.wr && bus.addr == URX_OFS_IRQ_MASK
         |=> st_r.imask == $past(bus.wdata[2:0]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write lost");

   property p_istat_set;
      @(posedge clk) disable iff (srst)
         ev != 3'h0
         |=> (st_r.istat & $past(ev)) == $past(ev);
   endproperty
   a_istat_set: assert property (p_istat_set) else $error("event not latched");

   property p_istat_clear;
      @(posedge clk) disable iff (srst)
         bus.wr && bus.addr == URX_OFS_IRQ_STAT && ev == 3'h0
         |=> (st_r.istat & $past(bus.wdata[2:0])) == 3'h0;
   endproperty
   a_istat_clear: assert property (p_istat_clear) else $error("status not cleared");

   property p_flush_event;
      @(posedge clk) disable iff (srst)
         disable_now && st_r.count != 2'h0
         |=> st_r.istat[URX_IRQ_FLUSH_BIT];
   endproperty
   a_flush_event: assert property (p_flush_event) else $error("flush loss not flagged");

   property p_perr_event;
      @(posedge clk) disable iff (srst)
         s_load_perr
         |=> st_r.istat[URX_IRQ_PERR_BIT];
   endproperty
   a_perr_event: assert property (p_perr_event) else $error("parity event not flagged");

   property p_stop_stored;
      @(posedge clk) disable iff (srst)
         s_load_empty
         |=> head.stop_ok == $past(shift_stop) && head.data == $past(shift_data);
   endproperty
   a_stop_stored: assert property (p_stop_stored) else $error("entry not stored");

   property p_data_read;
      @(posedge clk) disable iff (srst)
         do_read
         |=> reg_rdata == $past(head.data);
   endproperty
   a_data_read: assert property (p_data_read) else $error("head data not returned");

   property p_stat_after_read;
      @(posedge clk) disable iff (srst)
         do_read && !shift_load && st_r.count == 2'h2
         |=> head == $past(st_r.buf_q[~st_r.rptr]);
   endproperty
   a_stat_after_read: assert property (p_stat_after_read) else $error("next entry not presented");

   property p_unmapped;
      @(posedge clk) disable iff (srst)
         bus.rd && bus.addr > URX_OFS_IRQ_MASK
         |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : urx_parity_flush

// ==== verification/urx_frame_src.sv ====
// Purpose: far-side frame source handing finished frames to the receive block
// Assumes: one load pulse per frame; parity made from the mode the bench gives
// Notes: between frames the data lines toggle so stale values cannot pass
`timescale 1ns/100ps
module urx_frame_src (
   input wire logic clk,
   input wire logic srst,
   input wire logic go,
   input wire logic [7:0] fd,
   input wire logic bad,
   input wire logic odd_sel,
   output logic shift_load,
   output logic [7:0] shift_data,
   output logic shift_parity,
   output logic shift_stop
);
   always @(posedge clk) begin
      if (srst) begin
         shift_load <= 1'b0;
         shift_data <= 8'h00;
         shift_parity <= 1'b0;
         shift_stop <= 1'b0;
      end else if (go) begin
         shift_load <= 1'b1;
         shift_data <= fd;
         shift_parity <= ^fd ^ odd_sel ^ bad;
         shift_stop <= 1'b1;
      end else begin
         shift_load <= 1'b0;
         shift_data <= ~shift_data;
         shift_parity <= ~shift_parity;
         shift_stop <= ~shift_stop;
      end
   end
endmodule : urx_frame_src

// ==== verification/uart_rx_parity_and_flush_test.sv ====
// Purpose: self-checking bench for the receive parity and flush block
// Assumes: reads answer one cycle after the strobe
// Notes: expected read data queued by the driver, popped by a monitor
`timescale 1ns/100ps
module uart_rx_parity_and_flush_test
   import urx_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, shift_data, fd = 8'h00;
   logic shift_load, shift_parity, shift_stop, rx_enable, rx_pin_override, irq;
   logic go = 1'b0, bad = 1'b0, odd_sel = 1'b0, rd_seen = 1'b0;
   logic [7:0] exp_q[$];
   logic [16:0] seed = 17'h18462;
   int num_errors = 0;
   int checks_done = 0;
   always #5 clk = ~clk;
   urx_parity_flush u_urx_parity_flush (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_load(shift_load),
      .shift_data(shift_data), .shift_parity(shift_parity), .shift_stop(shift_stop),
      .rx_enable(rx_enable), .rx_pin_override(rx_pin_override), .irq(irq));
   urx_frame_src u_urx_frame_src (.clk(clk), .srst(srst), .go(go), .fd(fd), .bad(bad), .odd_sel(odd_sel),
      .shift_load(shift_load), .shift_data(shift_data), .shift_parity(shift_parity), .shift_stop(shift_stop));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= ~w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) exp_q.push_back(d);
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask : acc
   task automatic send(input logic [7:0] d, input logic b, input logic o);
      @(posedge clk);
      go <= 1'b1;
      fd <= d;
      bad <= b;
      odd_sel <= o;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : send
   task automatic outs(input logic [2:0] e);
      repeat (2) @(posedge clk);
      #1 cmp({5'h00, rx_enable, rx_pin_override, irq}, {5'h00, e});
   endtask : outs
   task conclude;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   // ------------------------------------------------------------
   // monitor, watchdog and sequence
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (rd_seen && exp_q.size() > 0) cmp(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
   end
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      conclude();
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      acc(1'b0, URX_OFS_CTRL, {5'h00, URX_CTRL_RST});
      acc(1'b0, URX_OFS_STAT, 8'h00);
      acc(1'b1, URX_OFS_IRQ_MASK, 8'h07);
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         acc(1'b1, URX_OFS_CTRL, {5'h00, k[1], k[0], 1'b1});
         send(seed[7:0], k[2], k[0]);
         acc(1'b0, URX_OFS_STAT, {5'h10, k[1] & k[2], 2'h0});
         acc(1'b0, URX_OFS_DATA, seed[7:0]);
      end
      outs(3'b111);
      acc(1'b0, URX_OFS_IRQ_STAT, 8'h03);
      acc(1'b1, URX_OFS_IRQ_STAT, 8'h03);
      outs(3'b110);
      acc(1'b1, URX_OFS_IRQ_MASK, 8'h00);
      acc(1'b1, URX_OFS_CTRL, 8'h05);
      seed = lfsr(seed);
      send(seed[7:0], 1'b1, 1'b0);
      send(~seed[7:0], 1'b0, 1'b0);
      send(8'h3c, 1'b0, 1'b0);
      outs(3'b110);
      acc(1'b0, URX_OFS_STAT, 8'h84);
      acc(1'b0, URX_OFS_STAT, 8'h84);
      acc(1'b0, URX_OFS_DATA, seed[7:0]);
      acc(1'b0, URX_OFS_STAT, 8'h80);
      acc(1'b0, URX_OFS_DATA, ~seed[7:0]);
      acc(1'b0, URX_OFS_DATA, 8'h00);
      acc(1'b0, URX_OFS_STAT, 8'h00);
      acc(1'b1, URX_OFS_IRQ_MASK, 8'h07);
      outs(3'b111);
      acc(1'b1, URX_OFS_IRQ_STAT, 8'h07);
      send(8'h01, 1'b1, 1'b0);
      acc(1'b1, URX_OFS_CTRL, 8'h01);
      acc(1'b0, URX_OFS_STAT, 8'h80);
      send(8'h02, 1'b0, 1'b0);
      acc(1'b1, URX_OFS_CTRL, 8'h00);
      outs(3'b001);
      acc(1'b0, URX_OFS_STAT, 8'h00);
      acc(1'b0, URX_OFS_IRQ_STAT, 8'h07);
      send(8'h03, 1'b0, 1'b0);
      acc(1'b1, URX_OFS_CTRL, 8'h01);
      outs(3'b111);
      acc(1'b0, URX_OFS_STAT, 8'h00);
      acc(1'b0, URX_OFS_DATA, 8'h00);
      acc(1'b0, 3'h5, 8'h00);
      repeat (2) @(posedge clk);
      conclude();
   end
endmodule : uart_rx_parity_and_flush_test
